// ===== core/bal_alu.sv
// Byte arithmetic and logic datapath with two-clock word add and subtract.
// Assumes the decoder holds its request stable until the done pulse.
`timescale 1ns/10ps
module bal_alu
	import bal_pkg::*;
#(
	parameter int WIDTH = BAL_WIDTH
) (
	input wire logic CLK_I,
	input wire logic SYS_RST_I,
	input wire bal_req_t REQ_I,
	output bal_res_t RES_O,
	output logic [BAL_FLAG_WIDTH-1:0] FLAGS_O,
	output logic BUSY_O
);
	typedef enum logic [1:0] {BAL_ST_IDLE, BAL_ST_WORD_HIGH} bal_state_t;

	bal_state_t state;
	bal_state_t next_state;
	logic word_carry;
	logic [BAL_FLAG_WIDTH-1:0] flags;
	logic [BAL_FLAG_WIDTH-1:0] next_update;
	logic [BAL_FLAG_WIDTH-1:0] next_value;
	bal_res_t next_res;

	// Byte add or subtract with carry-in, returns {half, carry, overflow, sum}
	function automatic logic [10:0] bal_addsub(input logic [7:0] a, input logic [7:0] b,
			input logic cin, input logic sub);
		logic [7:0] bb;
		logic [8:0] full;
		logic [4:0] low;
		logic [7:0] r;
		logic h;
		logic c;
		logic v;
		bb = sub ? ~b : b;
		full = {1'b0, a} + {1'b0, bb} + {8'h00, (sub ? ~cin : cin)};
		low = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, (sub ? ~cin : cin)};
		r = full[7:0];
		h = sub ? ~low[4] : low[4];
		c = sub ? ~full[8] : full[8];
		v = (a[7] == bb[7]) && (r[7] != a[7]);
		return {h, c, v, r};
	endfunction : bal_addsub

	// Decoded operation classes
	wire is_word_add = (REQ_I.op == BAL_OP_WORD_IMMEDIATE_ADD);
	wire is_word_sub = (REQ_I.op == BAL_OP_WORD_IMMEDIATE_MINUS);
	wire is_word = is_word_add || is_word_sub;
	wire carry_in = flags[BAL_FLAG_C];

	// Operand selection for the add/subtract path
	wire is_sub = (REQ_I.op == BAL_OP_MINUS) || (REQ_I.op == BAL_OP_IMMEDIATE_MINUS)
		|| (REQ_I.op == BAL_OP_BORROW_MINUS) || (REQ_I.op == BAL_OP_IMMEDIATE_BORROW_MINUS)
		|| (REQ_I.op == BAL_OP_SIGN_FLIP) || is_word_sub;
	wire use_imm = (REQ_I.op == BAL_OP_IMMEDIATE_MINUS)
		|| (REQ_I.op == BAL_OP_IMMEDIATE_BORROW_MINUS) || is_word;
	wire use_cin = (REQ_I.op == BAL_OP_CARRY_SUM) || (REQ_I.op == BAL_OP_BORROW_MINUS)
		|| (REQ_I.op == BAL_OP_IMMEDIATE_BORROW_MINUS);
	wire [7:0] arith_a = (REQ_I.op == BAL_OP_SIGN_FLIP) ? BAL_ALL_ZERO : REQ_I.dest_reg;
	wire [7:0] arith_b = (REQ_I.op == BAL_OP_SIGN_FLIP) ? REQ_I.dest_reg
		: (use_imm ? REQ_I.immediate_value : REQ_I.source_reg);
	wire arith_cin = use_cin ? carry_in : 1'b0;
	wire [10:0] arith = bal_addsub(arith_a, arith_b, arith_cin, is_sub);

	// High byte of the word path: pair high plus or minus the low carry
	wire [10:0] high = bal_addsub(REQ_I.dest_high, BAL_ALL_ZERO, word_carry, is_word_sub);
	wire [15:0] word_res = {high[7:0], RES_O.result_low};
	wire word_v = is_word_add ? (~REQ_I.dest_high[7] & high[7]) : (REQ_I.dest_high[7] & ~high[7]);
	wire word_c = is_word_add ? (~high[7] & REQ_I.dest_high[7]) : (high[7] & ~REQ_I.dest_high[7]);

	// Logic unit results
	wire [7:0] and_res = REQ_I.dest_reg & ((REQ_I.op == BAL_OP_IMMEDIATE_CONJUNCTION)
		? REQ_I.immediate_value : REQ_I.source_reg);
	wire [7:0] or_res = REQ_I.dest_reg | ((REQ_I.op == BAL_OP_IMMEDIATE_DISJUNCTION)
		|| (REQ_I.op == BAL_OP_BITS_SET_MASK) ? REQ_I.immediate_value : REQ_I.source_reg);
	wire [7:0] xor_res = REQ_I.dest_reg ^ REQ_I.source_reg;
	wire [7:0] inv_res = BAL_ALL_ONES - REQ_I.dest_reg;
	wire [7:0] clr_res = REQ_I.dest_reg & (BAL_ALL_ONES - REQ_I.immediate_value);

	// Result, flag values and flag update mask
	always_comb begin
		next_state = BAL_ST_IDLE;
		next_update = '0;
		next_value = '0;
		next_res = '0;
		case (state)
			BAL_ST_IDLE: begin
				if (REQ_I.start) begin
					next_res.write_low = 1'b1;
					next_res.done = 1'b1;
					case (REQ_I.op)
						BAL_OP_SUM, BAL_OP_CARRY_SUM,
						BAL_OP_MINUS, BAL_OP_IMMEDIATE_MINUS,
						BAL_OP_BORROW_MINUS,
						BAL_OP_IMMEDIATE_BORROW_MINUS,
						BAL_OP_SIGN_FLIP: begin
							next_res.result_low = arith[7:0];
							next_update = BAL_MASK_ARITH;
							next_value[BAL_FLAG_C] = arith[9];
							next_value[BAL_FLAG_V] = arith[8];
							next_value[BAL_FLAG_H] = arith[10];
						end
						BAL_OP_WORD_IMMEDIATE_ADD, BAL_OP_WORD_IMMEDIATE_MINUS: begin
							next_res.result_low = arith[7:0];
							next_res.done = 1'b0;
							next_state = BAL_ST_WORD_HIGH;
						end
						BAL_OP_CONJUNCTION, BAL_OP_IMMEDIATE_CONJUNCTION: begin
							next_res.result_low = and_res;
							next_update = BAL_MASK_LOGIC;
						end
						BAL_OP_DISJUNCTION, BAL_OP_IMMEDIATE_DISJUNCTION,
						BAL_OP_BITS_SET_MASK: begin
							next_res.result_low = or_res;
							next_update = BAL_MASK_LOGIC;
						end
						BAL_OP_XOR: begin
							next_res.result_low = xor_res;
							next_update = BAL_MASK_LOGIC;
						end
						BAL_OP_INVERT: begin
							next_res.result_low = inv_res;
							next_update = BAL_MASK_INVERT;
							next_value[BAL_FLAG_C] = 1'b1;
						end
						BAL_OP_BITS_CLEAR_MASK: begin
							next_res.result_low = clr_res;
							next_update = BAL_MASK_LOGIC;
						end
						default: begin
							next_res = '0;
						end
					endcase
					next_value[BAL_FLAG_Z] = (next_res.result_low == BAL_ALL_ZERO);
					next_value[BAL_FLAG_N] = next_res.result_low[7];
				end
			end
			BAL_ST_WORD_HIGH: begin
				next_res.write_high = 1'b1;
				next_res.done = 1'b1;
				next_res.result_low = RES_O.result_low;
				next_res.result_high = high[7:0];
				next_update = BAL_MASK_WORD;
				next_value[BAL_FLAG_Z] = (word_res == 16'h0000);
				next_value[BAL_FLAG_N] = high[7];
				next_value[BAL_FLAG_V] = word_v;
				next_value[BAL_FLAG_C] = word_c;
				next_value[BAL_FLAG_S] = high[7] ^ word_v;
			end
			default: begin
				next_state = BAL_ST_IDLE;
			end
		endcase
	end

	// State, low-byte carry and result registers
	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			state <= BAL_ST_IDLE;
			word_carry <= 1'b0;
			RES_O <= '0;
			BUSY_O <= 1'b0;
		end else begin
			state <= next_state;
			word_carry <= arith[9];
			RES_O <= next_res;
			BUSY_O <= (next_state == BAL_ST_WORD_HIGH);
		end
	end

	bal_flag_reg #(
		.FLAG_WIDTH(BAL_FLAG_WIDTH)
	) u_flags (
		.clk_i(CLK_I),
		.rst_i(SYS_RST_I),
		.update_i(next_update),
		.value_i(next_value),
		.flags_o(flags)
	);

	assign FLAGS_O = flags;
endmodule : bal_alu

// ===== common/bal_pkg.sv
// Package for the byte arithmetic and logic datapath.
// Assumes a single core clock and an external decoder holding operands stable.
package bal_pkg;
	localparam int BAL_WIDTH = 8;
	localparam int BAL_WORD_WIDTH = 16;
	localparam int BAL_FLAG_WIDTH = 6;
	// Flag positions in the status vector
	localparam int BAL_FLAG_C = 0;
	localparam int BAL_FLAG_Z = 1;
	localparam int BAL_FLAG_N = 2;
	localparam int BAL_FLAG_V = 3;
	localparam int BAL_FLAG_S = 4;
	localparam int BAL_FLAG_H = 5;
	localparam logic [5:0] BAL_FLAGS_RESET = 6'h00;
	localparam logic [7:0] BAL_BYTE_RESET = 8'h00;
	localparam logic [7:0] BAL_ALL_ONES = 8'hff;
	localparam logic [7:0] BAL_ALL_ZERO = 8'h00;
	// Clocks taken by each class of operation
	localparam int BAL_BYTE_CYCLES = 1;
	localparam int BAL_WORD_CYCLES = 2;
	// Flag update masks per operation class (bit order H S V N Z C)
	localparam logic [5:0] BAL_MASK_ARITH = 6'h2f;
	localparam logic [5:0] BAL_MASK_WORD = 6'h1f;
	localparam logic [5:0] BAL_MASK_LOGIC = 6'h0e;
	localparam logic [5:0] BAL_MASK_INVERT = 6'h0f;

	typedef enum logic [4:0] {
		BAL_OP_NONE,
		BAL_OP_SUM,
		BAL_OP_CARRY_SUM,
		BAL_OP_WORD_IMMEDIATE_ADD,
		BAL_OP_MINUS,
		BAL_OP_IMMEDIATE_MINUS,
		BAL_OP_BORROW_MINUS,
		BAL_OP_IMMEDIATE_BORROW_MINUS,
		BAL_OP_WORD_IMMEDIATE_MINUS,
		BAL_OP_CONJUNCTION,
		BAL_OP_IMMEDIATE_CONJUNCTION,
		BAL_OP_DISJUNCTION,
		BAL_OP_IMMEDIATE_DISJUNCTION,
		BAL_OP_XOR,
		BAL_OP_INVERT,
		BAL_OP_SIGN_FLIP,
		BAL_OP_BITS_SET_MASK,
		BAL_OP_BITS_CLEAR_MASK
	} bal_op_t;

	// Request from the decoder and register file
	typedef struct packed {
		logic start;
		bal_op_t op;
		logic [7:0] dest_reg;
		logic [7:0] source_reg;
		logic [7:0] dest_high;
		logic [7:0] immediate_value;
	} bal_req_t;

	// Result handed back to the register file
	typedef struct packed {
		logic done;
		logic write_low;
		logic write_high;
		logic [7:0] result_low;
		logic [7:0] result_high;
	} bal_res_t;
endpackage : bal_pkg

// ===== core/bal_flag_reg.sv
// Status flag holder with per-bit update enable.
// Assumes the datapath supplies a mask of flags the current operation touches.
`timescale 1ns/10ps
module bal_flag_reg
	import bal_pkg::*;
#(
	parameter int FLAG_WIDTH = BAL_FLAG_WIDTH
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [FLAG_WIDTH-1:0] update_i,
	input wire logic [FLAG_WIDTH-1:0] value_i,
	output logic [FLAG_WIDTH-1:0] flags_o
);
	// Each flag loads only when its update bit is set
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			flags_o <= BAL_FLAGS_RESET;
		end else begin
			flags_o <= (flags_o & ~update_i) | (value_i & update_i);
		end
	end
endmodule : bal_flag_reg

// ===== tb/bal_alu_properties.sv
// Checker for the byte datapath: latency, pulses, flag keeping, values.
// Assumes binding onto the datapath top and one core clock domain.
`timescale 1ns/10ps
module bal_alu_properties
	import bal_pkg::*;
(
	input wire logic CLK_I,
	input wire logic SYS_RST_I,
	input wire bal_req_t REQ_I,
	input wire bal_res_t RES_O,
	input wire logic [BAL_FLAG_WIDTH-1:0] FLAGS_O,
	input wire logic BUSY_O
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (SYS_RST_I);
	// Classes of accepted request
	wire logic take = REQ_I.start && !BUSY_O;
	wire logic word = take
		&& REQ_I.op inside {BAL_OP_WORD_IMMEDIATE_ADD, BAL_OP_WORD_IMMEDIATE_MINUS};
	wire logic byte_op = take && !word && REQ_I.op != BAL_OP_NONE
		&& REQ_I.op <= BAL_OP_BITS_CLEAR_MASK;
	wire logic logic_op = take && REQ_I.op >= BAL_OP_CONJUNCTION && REQ_I.op <= BAL_OP_XOR;
	a_byte_one_clock: assert property (
		byte_op |=> RES_O.done && RES_O.write_low && !BUSY_O)
		else $error("byte op not done in one clock");
	a_word_first_clock: assert property (
		word |=> BUSY_O && RES_O.write_low && !RES_O.done)
		else $error("word op first clock wrong");
	a_word_second_clock: assert property (
		word |=> ##1 RES_O.done && RES_O.write_high && !BUSY_O)
		else $error("word op not done in two clocks");
	a_word_add_value: assert property (
		word && REQ_I.op == BAL_OP_WORD_IMMEDIATE_ADD |=> ##1
		{RES_O.result_high, RES_O.result_low} ==
		$past({REQ_I.dest_high, REQ_I.dest_reg} + REQ_I.immediate_value, 2))
		else $error("word add result wrong");
	a_word_keeps_half: assert property (
		word |=> ##1 FLAGS_O[BAL_FLAG_H] == $past(FLAGS_O[BAL_FLAG_H], 2))
		else $error("word op changed H");
	a_logic_flags_kept: assert property (
		logic_op |=> !FLAGS_O[BAL_FLAG_V]
		&& $stable({FLAGS_O[BAL_FLAG_C], FLAGS_O[BAL_FLAG_H]}))
		else $error("logic op flags wrong");
	a_and_value_ok: assert property (
		take && REQ_I.op == BAL_OP_CONJUNCTION |=>
		RES_O.result_low == $past(REQ_I.dest_reg & REQ_I.source_reg))
		else $error("AND wrong");
	a_xor_value_ok: assert property (
		take && REQ_I.op == BAL_OP_XOR |=>
		RES_O.result_low == $past(REQ_I.dest_reg ^ REQ_I.source_reg))
		else $error("XOR wrong");
	a_invert_sets_carry: assert property (
		take && REQ_I.op == BAL_OP_INVERT |=>
		FLAGS_O[BAL_FLAG_C] && RES_O.result_low == ~$past(REQ_I.dest_reg))
		else $error("invert wrong");
	a_zero_flag_match: assert property (
		RES_O.done && !RES_O.write_high |-> FLAGS_O[BAL_FLAG_Z] == (RES_O.result_low == 8'h00))
		else $error("zero flag wrong");
	a_sum_value_ok: assert property (
		take && REQ_I.op == BAL_OP_SUM |=>
		RES_O.result_low == $past(8'(REQ_I.dest_reg + REQ_I.source_reg)))
		else $error("sum wrong");
	a_clear_value_ok: assert property (
		take && REQ_I.op == BAL_OP_BITS_CLEAR_MASK |=>
		RES_O.result_low == $past(REQ_I.dest_reg & ~REQ_I.immediate_value))
		else $error("clear mask wrong");
	a_busy_one_clock: assert property (
		BUSY_O |=> !BUSY_O)
		else $error("busy held too long");
	c_byte_op: cover property (byte_op ##1 byte_op);
	c_word_op: cover property (word ##2 RES_O.done);
	c_logic_op: cover property (logic_op);
endmodule : bal_alu_properties

bind bal_alu bal_alu_properties u_bal_alu_properties (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I),
	.REQ_I(REQ_I), .RES_O(RES_O), .FLAGS_O(FLAGS_O), .BUSY_O(BUSY_O));

// ===== tb/bal_regfile_model.sv
// Decoder and register file model facing the datapath.
// Assumes commands arrive from the bench off the rising edge.
`timescale 1ns/10ps
module bal_regfile_model
	import bal_pkg::*;
(
	input wire logic clk_i,
	input wire bal_req_t cmd_i,
	input wire logic busy_i,
	input wire bal_res_t res_i,
	output bal_req_t req_o,
	output logic [15:0] pair_o
);
	bal_req_t held;
	// request held over second word clock
	assign req_o = busy_i ? held : cmd_i;
	// Capture request and written-back bytes
	always_ff @(posedge clk_i) begin
		held <= req_o;
		if (res_i.write_low) pair_o[7:0] <= res_i.result_low;
		if (res_i.write_high) pair_o[15:8] <= res_i.result_high;
	end
endmodule : bal_regfile_model

// ===== tb/byte_alu_arith_logic_test.sv
// Self-checking bench: byte op table, word ops, unknown op, mid-run reset.
// Assumes the register file model in front of the datapath.
`timescale 1ns/10ps
module byte_alu_arith_logic_test
	import bal_pkg::*;
;
	typedef struct {bal_op_t op; logic [7:0] d, s, k, r; logic [5:0] f;} bal_row_t;
	logic clk, rst;
	bal_req_t cmd, req;
	bal_res_t res;
	logic [5:0] flags;
	logic busy;
	logic [15:0] pair;
	int errors, n_checks;
	// Rows run in order, so kept flags follow from the row before
	bal_row_t rows [16] = '{
		'{BAL_OP_SUM, 8'h7f, 8'h01, 8'h00, 8'h80, 6'h2c},
		'{BAL_OP_CARRY_SUM, 8'hff, 8'h01, 8'h00, 8'h00, 6'h23},
		'{BAL_OP_CARRY_SUM, 8'h01, 8'h01, 8'h00, 8'h03, 6'h00},
		'{BAL_OP_MINUS, 8'h00, 8'h01, 8'h00, 8'hff, 6'h25},
		'{BAL_OP_BORROW_MINUS, 8'h05, 8'h02, 8'h00, 8'h02, 6'h00},
		'{BAL_OP_IMMEDIATE_MINUS, 8'h80, 8'h00, 8'h01, 8'h7f, 6'h28},
		'{BAL_OP_IMMEDIATE_BORROW_MINUS, 8'h10, 8'h00, 8'h20, 8'hf0, 6'h05},
		'{BAL_OP_CONJUNCTION, 8'hf0, 8'h8f, 8'h00, 8'h80, 6'h05},
		'{BAL_OP_IMMEDIATE_CONJUNCTION, 8'h0f, 8'hff, 8'hf0, 8'h00, 6'h03},
		'{BAL_OP_DISJUNCTION, 8'h00, 8'h00, 8'hff, 8'h00, 6'h03},
		'{BAL_OP_IMMEDIATE_DISJUNCTION, 8'h01, 8'h00, 8'h80, 8'h81, 6'h05},
		'{BAL_OP_XOR, 8'hff, 8'h0f, 8'h00, 8'hf0, 6'h05},
		'{BAL_OP_INVERT, 8'hff, 8'h00, 8'h00, 8'h00, 6'h03},
		'{BAL_OP_SIGN_FLIP, 8'h01, 8'h00, 8'h00, 8'hff, 6'h25},
		'{BAL_OP_BITS_SET_MASK, 8'h10, 8'h00, 8'h81, 8'h91, 6'h25},
		'{BAL_OP_BITS_CLEAR_MASK, 8'h91, 8'h00, 8'h91, 8'h00, 6'h23}};
	bal_alu u_bal_alu (.CLK_I(clk), .SYS_RST_I(rst), .REQ_I(req), .RES_O(res),
		.FLAGS_O(flags), .BUSY_O(busy));
	bal_regfile_model u_bal_regfile_model (.clk_i(clk), .cmd_i(cmd), .busy_i(busy),
		.res_i(res), .req_o(req), .pair_o(pair));
	// Core clock, 20 ns period
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Wide enough for the whole result struct with flags and busy
	task automatic chk(input logic [31:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Word op: low byte after one clock, high byte and flags after two
	task automatic word_op(input bal_op_t op, input logic [15:0] p, r, input logic [7:0] k,
		input logic [5:0] f);
		cmd <= '{1'b1, op, p[7:0], 8'h00, p[15:8], k};
		@(negedge clk);
		chk({busy, res.write_low, res.done, res.result_low}, {3'b110, r[7:0]});
		cmd <= '0;
		@(negedge clk);
		chk({busy, res.done, res.write_high, res.result_high}, {3'b011, r[15:8]});
		// Register file stores the high byte one edge after the write pulse
		@(negedge clk);
		chk({pair, flags}, {r, f});
	endtask : word_op
	task automatic give_verdict;
		if (errors == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : give_verdict
	initial begin
		rst = 1'b1;
		cmd = '0;
		errors = 0;
		n_checks = 0;
		repeat (10) @(negedge clk);
		rst <= 1'b0;
		// Back-to-back byte ops, one per clock
		foreach (rows[i]) begin
			cmd <= '{1'b1, rows[i].op, rows[i].d, rows[i].s, 8'h00, rows[i].k};
			@(negedge clk);
			chk({res.done, res.write_low, res.result_low, flags}, {2'b11, rows[i].r, rows[i].f});
		end
		word_op(BAL_OP_WORD_IMMEDIATE_ADD, 16'h7fff, 16'h8000, 8'h01, 6'h2c);
		word_op(BAL_OP_WORD_IMMEDIATE_MINUS, 16'h0000, 16'hffff, 8'h01, 6'h35);
		word_op(BAL_OP_WORD_IMMEDIATE_ADD, 16'hffff, 16'h0000, 8'h01, 6'h23);
		// Start with no operation gives no answer and keeps flags
		cmd <= '{1'b1, BAL_OP_NONE, 8'h00, 8'h00, 8'h00, 8'h00};
		repeat (2) begin
			@(negedge clk);
			chk({res.done, flags}, {1'b0, 6'h23});
		end
		cmd <= '0;
		// Mid-run reset clears results, flags and busy
		rst <= 1'b1;
		@(negedge clk);
		chk({res, flags, busy}, '0);
		// Release and run one add from cleared flags
		rst <= 1'b0;
		cmd <= '{1'b1, BAL_OP_SUM, 8'h01, 8'h01, 8'h00, 8'h00};
		@(negedge clk);
		chk({res.done, res.write_low, res.result_low, flags}, {2'b11, 8'h02, 6'h00});
		cmd <= '0;
		give_verdict();
	end
endmodule : byte_alu_arith_logic_test
